/* core/fwsr_defs.vh */
// constants for the flash write and status controller
`ifndef FWSR_DEFS_VH
`define FWSR_DEFS_VH
// ------------------------------------------------------------
// apb register map (byte offsets)
// ------------------------------------------------------------
`define FWSR_REG_CMD      12'h000
`define FWSR_REG_ADDR     12'h004
`define FWSR_REG_DATA     12'h008
`define FWSR_REG_STATUS   12'h00c
`define FWSR_REG_RDATA    12'h010
// ------------------------------------------------------------
// command codes written to the command register
// ------------------------------------------------------------
`define FWSR_OP_READ      3'h0
`define FWSR_OP_RESET     3'h1
`define FWSR_OP_PROGRAM   3'h2
`define FWSR_OP_SECERASE  3'h3
`define FWSR_OP_CHIPERASE 3'h4
`define FWSR_OP_SUSPEND   3'h5
`define FWSR_OP_RESUME    3'h6
`define FWSR_OP_AUTOSEL   3'h7
// ------------------------------------------------------------
// device command bytes and unlock addresses (word mode)
// ------------------------------------------------------------
`define FWSR_UNLOCK1_ADDR 17'h00555
`define FWSR_UNLOCK2_ADDR 17'h002aa
`define FWSR_UNLOCK1_DATA 8'haa
`define FWSR_UNLOCK2_DATA 8'h55
`define FWSR_CODE_RESET   8'hf0
`define FWSR_CODE_PROGRAM 8'ha0
`define FWSR_CODE_ERASE   8'h80
`define FWSR_CODE_CHIP    8'h10
`define FWSR_CODE_SECTOR  8'h30
`define FWSR_CODE_SUSPEND 8'hb0
`define FWSR_CODE_RESUME  8'h30
`define FWSR_CODE_AUTOSEL 8'h90
// ------------------------------------------------------------
// data bit positions and status register fields
// ------------------------------------------------------------
`define FWSR_BIT_POLL     7
`define FWSR_BIT_TOGGLE1  6
`define FWSR_BIT_LIMIT    5
`define FWSR_BIT_WINDOW   3
`define FWSR_BIT_TOGGLE2  2
`define FWSR_ST_BUSY      0
`define FWSR_ST_DONE      1
`define FWSR_ST_FAIL      2
`define FWSR_ST_RDYPIN    3
`define FWSR_ST_WINDOW    4
// ------------------------------------------------------------
// bus cycle timing in pclk cycles (40 ns each)
// ------------------------------------------------------------
`define FWSR_STROBE_NS    80
`define FWSR_PERIOD_NS    40
`define FWSR_STROBE_CYC   ((`FWSR_STROBE_NS + `FWSR_PERIOD_NS - 1) / `FWSR_PERIOD_NS)
`endif

/* core/fwsr_cycle.v */
// one asynchronous flash bus cycle, read or write
`include "fwsr_defs.vh"
module fwsr_cycle #(
    parameter AW  = 17,
    parameter DW  = 16,
    parameter CYC = `FWSR_STROBE_CYC
) (
    // clock and reset
    input  wire          pclk,
    input  wire          presetn,
    // request
    input  wire          start,
    input  wire          write,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output wire          busy,
    output reg           done,
    output reg  [DW-1:0] rdata,
    // flash pins
    output reg  [AW-1:0] flash_addr,
    output reg  [DW-1:0] flash_dq_out,
    output reg           flash_dq_oe,
    input  wire [DW-1:0] flash_dq_in,
    output reg           chip_select_n,
    output reg           write_strobe_n,
    output reg           output_strobe_n
);
    localparam S_IDLE = 2'd0;
    localparam S_SET  = 2'd1;
    localparam S_STRB = 2'd2;
    localparam S_HOLD = 2'd3;
    reg [1:0] state;
    reg [7:0] cnt;
    reg       is_wr;
    assign busy = (state != S_IDLE);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state           <= S_IDLE;
            cnt             <= 8'h00;
            is_wr           <= 1'b0;
            done            <= 1'b0;
            rdata           <= {DW{1'b0}};
            flash_addr      <= {AW{1'b0}};
            flash_dq_out    <= {DW{1'b0}};
            flash_dq_oe     <= 1'b0;
            chip_select_n   <= 1'b1;
            write_strobe_n  <= 1'b1;
            output_strobe_n <= 1'b1;
        end else begin
            done <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start) begin
                        // address settles before the strobe so the late falling edge latches it
                        flash_addr    <= addr;
                        flash_dq_out  <= wdata;
                        flash_dq_oe   <= write;
                        is_wr         <= write;
                        chip_select_n <= 1'b0;
                        state         <= S_SET;
                    end
                end
                S_SET: begin
                    write_strobe_n  <= ~is_wr;
                    output_strobe_n <= is_wr;
                    cnt             <= CYC[7:0];
                    state           <= S_STRB;
                end
                S_STRB: begin
                    if (cnt > 8'h01) begin
                        cnt <= cnt - 8'h01;
                    end else begin
                        if (!is_wr) begin
                            rdata <= flash_dq_in;
                        end
                        write_strobe_n  <= 1'b1;
                        output_strobe_n <= 1'b1;
                        state           <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    // data held one cycle past the write strobe's rise
                    chip_select_n <= 1'b1;
                    flash_dq_oe   <= 1'b0;
                    done          <= 1'b1;
                    state         <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule

/* core/fwsr_ctrl.v */
// flash host controller: apb commands to flash command sequences and status polling
//
// Notes on behaviour
// - address at late fall, data early rise
// - array read needs no unlock cycles
// - reset command leaves autoselect or failure
// - autoselect fourth cycle is a read
// - poll bit inverted until program done
// - erase polls zero until done
// - read again after poll turns true
//
// Added by the designer: the register offsets and the APB register port.
`include "fwsr_defs.vh"
module fwsr_ctrl #(
    parameter AW = 17,
    parameter DW = 16
) (
    // clock and reset
    input  wire          pclk,
    input  wire          presetn,
    // apb slave
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    // flash pins
    output wire [AW-1:0] flash_addr,
    output wire [DW-1:0] flash_dq_out,
    output wire          flash_dq_oe,
    input  wire [DW-1:0] flash_dq_in,
    output wire          chip_select_n,
    output wire          write_strobe_n,
    output wire          output_strobe_n,
    output wire          reset_n,
    input  wire          ready_busy_n
);
    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    localparam S_IDLE  = 3'd0;
    localparam S_ISSUE = 3'd1;
    localparam S_WAIT  = 3'd2;
    localparam S_POLL1 = 3'd3;
    localparam S_POLL2 = 3'd4;
    localparam S_CHECK = 3'd5;
    localparam S_FINAL = 3'd6;

    reg [2:0]    state;
    reg [2:0]    op;
    reg [AW-1:0] target;
    reg [DW-1:0] value;
    reg [2:0]    step;
    reg [2:0]    nsteps;
    reg          busy_f;
    reg          done_f;
    reg          fail_f;
    reg          window_f;
    reg [DW-1:0] last_rd;
    reg [DW-1:0] first_rd;
    reg          limit_seen;
    reg          cyc_start;
    reg          cyc_write;
    reg [AW-1:0] cyc_addr;
    reg [DW-1:0] cyc_wdata;
    wire         cyc_done;
    wire [DW-1:0] cyc_rdata;
    reg          rb_s;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign reset_n = presetn;

    // ------------------------------------------------------------
    // apb register access
    // ------------------------------------------------------------
    wire wr_en = psel && penable && pwrite;
    wire rd_en = psel && !penable && !pwrite;
    wire cmd_go = wr_en && (paddr == `FWSR_REG_CMD) && !busy_f;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            case (paddr)
                `FWSR_REG_CMD:    prdata <= {29'h0, op};
                `FWSR_REG_ADDR:   prdata <= {{(32-AW){1'b0}}, target};
                `FWSR_REG_DATA:   prdata <= {{(32-DW){1'b0}}, value};
                `FWSR_REG_STATUS: prdata <= {27'h0, window_f, rb_s, fail_f, done_f, busy_f};
                `FWSR_REG_RDATA:  prdata <= {{(32-DW){1'b0}}, last_rd};
                default:          prdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // command sequence tables
    // ------------------------------------------------------------
    // plain read is one cycle, no unlock
    function [2:0] seq_len;
        input [2:0] o;
        begin
            case (o)
                `FWSR_OP_READ:      seq_len = 3'd1;
                `FWSR_OP_RESET:     seq_len = 3'd1;
                `FWSR_OP_SUSPEND:   seq_len = 3'd1;
                `FWSR_OP_RESUME:    seq_len = 3'd1;
                `FWSR_OP_PROGRAM:   seq_len = 3'd4;
                `FWSR_OP_AUTOSEL:   seq_len = 3'd4;
                default:            seq_len = 3'd6;
            endcase
        end
    endfunction

    function step_is_read;
        input [2:0] o;
        input [2:0] s;
        begin
            step_is_read = (o == `FWSR_OP_READ) ||
                           ((o == `FWSR_OP_AUTOSEL) && (s == 3'd3));
        end
    endfunction

    // commands carry data in the low byte only
    function [DW-1:0] low_byte;
        input [7:0] b;
        begin
            low_byte = {{(DW-8){1'b0}}, b};
        end
    endfunction

    always @* begin
        cyc_write = !step_is_read(op, step);
        cyc_addr  = `FWSR_UNLOCK1_ADDR;
        cyc_wdata = low_byte(`FWSR_UNLOCK1_DATA);
        case (step)
            3'd1, 3'd4: begin
                cyc_addr  = `FWSR_UNLOCK2_ADDR;
                cyc_wdata = low_byte(`FWSR_UNLOCK2_DATA);
            end
            3'd2: begin
                case (op)
                    `FWSR_OP_PROGRAM: cyc_wdata = low_byte(`FWSR_CODE_PROGRAM);
                    `FWSR_OP_AUTOSEL: cyc_wdata = low_byte(`FWSR_CODE_AUTOSEL);
                    default:          cyc_wdata = low_byte(`FWSR_CODE_ERASE);
                endcase
            end
            3'd3: begin
                if (op == `FWSR_OP_PROGRAM || op == `FWSR_OP_AUTOSEL) begin
                    cyc_addr  = target;
                    cyc_wdata = value;
                end
            end
            3'd5: begin
                // sector erase addressed by sector bits
                if (op == `FWSR_OP_SECERASE) begin
                    cyc_addr  = target;
                    cyc_wdata = low_byte(`FWSR_CODE_SECTOR);
                end else begin
                    cyc_wdata = low_byte(`FWSR_CODE_CHIP);
                end
            end
            default: cyc_addr = `FWSR_UNLOCK1_ADDR;
        endcase
        // single-cycle commands override the table
        if (nsteps == 3'd1) begin
            case (op)
                `FWSR_OP_RESET:   cyc_wdata = low_byte(`FWSR_CODE_RESET);
                `FWSR_OP_SUSPEND: cyc_wdata = low_byte(`FWSR_CODE_SUSPEND);
                `FWSR_OP_RESUME:  cyc_wdata = low_byte(`FWSR_CODE_RESUME);
                default:          cyc_wdata = value;
            endcase
            cyc_addr = target;
        end
        // in-progress polling reads at the target
        if (state == S_POLL1 || state == S_POLL2 || state == S_FINAL) begin
            cyc_write = 1'b0;
            cyc_addr  = target;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    wire is_long = (op == `FWSR_OP_PROGRAM) || (op == `FWSR_OP_SECERASE) ||
                   (op == `FWSR_OP_CHIPERASE) || (op == `FWSR_OP_RESUME);
    wire tog1 = first_rd[`FWSR_BIT_TOGGLE1] ^ cyc_rdata[`FWSR_BIT_TOGGLE1];
    wire poll_true = (op == `FWSR_OP_PROGRAM) ?
        (cyc_rdata[`FWSR_BIT_POLL] == value[`FWSR_BIT_POLL]) : cyc_rdata[`FWSR_BIT_POLL];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= S_IDLE;
            op         <= `FWSR_OP_READ;
            target     <= {AW{1'b0}};
            value      <= {DW{1'b0}};
            step       <= 3'd0;
            nsteps     <= 3'd1;
            busy_f     <= 1'b0;
            done_f     <= 1'b0;
            fail_f     <= 1'b0;
            window_f   <= 1'b0;
            last_rd    <= {DW{1'b0}};
            first_rd   <= {DW{1'b0}};
            limit_seen <= 1'b0;
            cyc_start  <= 1'b0;
            rb_s       <= 1'b1;
        end else begin
            cyc_start <= 1'b0;
            rb_s      <= ready_busy_n;
            if (wr_en && !busy_f && paddr == `FWSR_REG_ADDR) begin
                target <= pwdata[AW-1:0];
            end
            if (wr_en && !busy_f && paddr == `FWSR_REG_DATA) begin
                value <= pwdata[DW-1:0];
            end
            if (wr_en && paddr == `FWSR_REG_CMD && state > S_WAIT && op == `FWSR_OP_SECERASE &&
                pwdata[2:0] == `FWSR_OP_SUSPEND) begin
                op     <= `FWSR_OP_SUSPEND;
                nsteps <= 3'd1;
            end
            case (state)
                S_IDLE: begin
                    if (cmd_go) begin
                        op        <= pwdata[2:0];
                        nsteps    <= seq_len(pwdata[2:0]);
                        step      <= 3'd0;
                        busy_f    <= 1'b1;
                        done_f    <= 1'b0;
                        fail_f    <= 1'b0;
                        state     <= S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    cyc_start <= 1'b1;
                    state     <= S_WAIT;
                end
                S_WAIT: begin
                    if (cyc_done) begin
                        if (!cyc_write) begin
                            last_rd <= cyc_rdata;
                        end
                        if (step + 3'd1 < nsteps) begin
                            step  <= step + 3'd1;
                            state <= S_ISSUE;
                        end else if (is_long) begin
                            // status valid after last strobe rise
                            cyc_start <= 1'b1;
                            state     <= S_POLL1;
                        end else begin
                            busy_f <= 1'b0;
                            done_f <= 1'b1;
                            state  <= S_IDLE;
                        end
                    end
                end
                S_POLL1: begin
                    if (cyc_done) begin
                        first_rd  <= cyc_rdata;
                        cyc_start <= 1'b1;
                        state     <= S_POLL2;
                    end
                end
                S_POLL2: begin
                    if (cyc_done) begin
                        window_f   <= cyc_rdata[`FWSR_BIT_WINDOW];
                        limit_seen <= cyc_rdata[`FWSR_BIT_LIMIT];
                        state      <= S_CHECK;
                        last_rd    <= cyc_rdata;
                    end
                end
                S_CHECK: begin
                    // protected cases settle the same way
                    if (!tog1 || poll_true) begin
                        cyc_start <= 1'b1;
                        state     <= S_FINAL;
                    end else if (op == `FWSR_OP_SUSPEND) begin
                        state <= S_ISSUE;
                    end else if (limit_seen) begin
                        // still toggling: failed
                        fail_f <= 1'b1;
                        busy_f <= 1'b0;
                        state  <= S_IDLE;
                    end else begin
                        cyc_start <= 1'b1;
                        state     <= S_POLL1;
                    end
                end
                S_FINAL: begin
                    // fresh read after poll turns true
                    if (cyc_done) begin
                        last_rd <= cyc_rdata;
                        busy_f  <= 1'b0;
                        done_f  <= 1'b1;
                        state   <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // protect result and toggle_two in raw read data
    // ready pin to status, dq driven on writes only
    fwsr_cycle #(
        .AW (AW),
        .DW (DW)
    ) u_cycle (
        .pclk            (pclk),
        .presetn         (presetn),
        .start           (cyc_start),
        .write           (cyc_write),
        .addr            (cyc_addr),
        .wdata           (cyc_wdata),
        .busy            (),
        .done            (cyc_done),
        .rdata           (cyc_rdata),
        .flash_addr      (flash_addr),
        .flash_dq_out    (flash_dq_out),
        .flash_dq_oe     (flash_dq_oe),
        .flash_dq_in     (flash_dq_in),
        .chip_select_n   (chip_select_n),
        .write_strobe_n  (write_strobe_n),
        .output_strobe_n (output_strobe_n)
    );
endmodule

/* bench/fwsr_ctrl_sva.sv */
// assertions on the flash pins of the controller
module fwsr_ctrl_sva #(
    parameter AW = 17,
    parameter DW = 16
) (
    // clock and reset
    input wire          pclk,
    input wire          presetn,
    // flash pins
    input wire [AW-1:0] flash_addr,
    input wire [DW-1:0] flash_dq_out,
    input wire          flash_dq_oe,
    input wire          chip_select_n,
    input wire          write_strobe_n,
    input wire          output_strobe_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_strobe_excl;
        !(!write_strobe_n && !output_strobe_n);
    endproperty
    a_strobe_excl: assert property (p_strobe_excl)
        else $error("write and output strobes low together");
    property p_we_in_cs;
        !write_strobe_n |-> !chip_select_n && flash_dq_oe;
    endproperty
    a_we_in_cs: assert property (p_we_in_cs)
        else $error("write strobe without select or driven data");
    property p_oe_reads;
        !output_strobe_n |-> !chip_select_n && !flash_dq_oe;
    endproperty
    a_oe_reads: assert property (p_oe_reads)
        else $error("host drives data during a read");
    property p_addr_hold;
        !chip_select_n && $past(!chip_select_n) |-> $stable(flash_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved while selected");
    property p_data_hold;
        !write_strobe_n || $rose(write_strobe_n) |-> $stable(flash_dq_out);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("write data moved before strobe rise");
    property p_we_width;
        $fell(write_strobe_n) |-> ##1 !write_strobe_n ##1 write_strobe_n;
    endproperty
    a_we_width: assert property (p_we_width)
        else $error("write strobe not two cycles wide");
    property p_cs_lead;
        $fell(write_strobe_n) |-> $past(!chip_select_n);
    endproperty
    a_cs_lead: assert property (p_cs_lead)
        else $error("select did not lead the write strobe");
    property p_cs_trail;
        $rose(write_strobe_n) |-> !chip_select_n;
    endproperty
    a_cs_trail: assert property (p_cs_trail)
        else $error("select rose before the write strobe");
    property p_oe_release;
        $rose(chip_select_n) |-> !flash_dq_oe;
    endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("data still driven after deselect");
endmodule

/* bench/fwsr_flash_model.sv */
// behavioural flash device facing the controller pins
module fwsr_flash_model #(
    parameter       DONE_NS  = 4000,
    parameter       PROT_NS  = 2000,
    parameter [4:0] LOCKED   = 5'h1f,
    parameter [7:0] MAKER_ID = 8'h3c, // arbitrary value
    parameter [7:0] PART_ID  = 8'hc3  // arbitrary value
) (
    // flash pins
    input  logic [16:0] addr,
    input  logic [15:0] dq_host,
    input  logic        dq_host_oe,
    input  logic        cs_n,
    input  logic        we_n,
    input  logic        oe_n,
    output logic [15:0] dq,
    output logic        ready_busy_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [int];
    logic [15:0] pd = 16'h0, dout = 16'h0;
    logic [16:0] la, pa;
    logic [4:0]  esec = 5'h0;
    logic        t1 = 0, t2 = 0, lf = 0, win = 0, prot = 0, chip = 0, arm = 0, fail_next = 0;
    int          mode = 0, cyc = 0;
    time         done_t, win_t;
    wire         wr_n  = cs_n | we_n;
    wire         rd_n  = cs_n | oe_n;
    wire         busy  = mode == 1 || mode == 2 || mode == 4;
    wire         insec = chip || addr[16:12] == esec;
    wire  [7:0]  d     = dq_host[7:0];
    wire  [10:0] a     = la[10:0];

    function automatic logic [15:0] word(input logic [16:0] k);
        return mem.exists(k) ? mem[k] : 16'hffff;
    endfunction
    task automatic start(input int m);
        mode = m;
        win = 0;
        done_t = $time + (prot ? (m == 2 ? 50 * PROT_NS : PROT_NS) : (m == 2 ? 4 : 1) * DONE_NS);
        win_t = $time + 1000;
    endtask
    // driven low only while an algorithm runs, driven high otherwise
    assign ready_busy_n = busy ? 1'b0 : 1'b1;
    assign dq = dq_host_oe ? dq_host : !rd_n ? dout : ~dout;
    // location taken at the later falling edge
    always @(negedge wr_n) la = addr;
    // value at the earlier rise, low byte for commands, full word for program data
    always @(posedge wr_n) begin
        if (d == 8'hf0 && (mode == 0 || mode == 5 || lf)) begin
            mode = 0;
            lf = 0;
            cyc = 0;
        end else if (d == 8'hb0 && mode == 2 && !chip) mode = 3;
        else if (d == 8'h30 && mode == 3 && cyc == 0) start(2);
        else if (busy) cyc = 0;
        else if (cyc == 0) cyc = (a == 11'h555 && d == 8'haa) ? 1 : 0;
        else if (cyc == 1) cyc = (a == 11'h2aa && d == 8'h55) ? 2 : 0;
        else if (cyc == 2 && arm) begin
            arm = 0;
            cyc = 0;
            chip = d == 8'h10;
            esec = la[16:12];
            prot = !chip && esec == LOCKED;
            if (chip || d == 8'h30) start(2);
        end else if (cyc == 2 && a == 11'h555) begin
            cyc = d == 8'ha0 ? 3 : 0;
            arm = d == 8'h80 && mode == 0;
            if (d == 8'h90) mode = 5;
        end else if (cyc == 3) begin
            cyc = 0;
            pa = la;
            pd = dq_host;
            prot = la[16:12] == LOCKED;
            start(mode == 3 ? 4 : 1);
        end else cyc = 0;
    end
    // finish, fail or close the erase window
    always #20 begin
        if (mode == 2 && $time >= win_t) win = 1;
        if (busy && $time >= done_t && fail_next) lf = 1;
        else if (busy && $time >= done_t && !lf) begin
            if (mode != 2 && !prot) mem[pa] = word(pa) & pd;
            if (mode == 2 && !prot)
                foreach (mem[k]) if (chip ? k[16:12] != LOCKED : k[16:12] == esec) mem[k] = 16'hffff;
            mode = mode == 4 ? 3 : 0;
        end
    end
    always @(negedge rd_n) begin
        if (mode == 5)
            dout = addr[1:0] == 2'h0 ? {8'h0, MAKER_ID} : addr[1:0] == 2'h1 ? {8'h0, PART_ID}
                 : {15'h0, addr[16:12] == LOCKED};
        else if (mode == 1 || mode == 4) dout = {8'h0, ~pd[7], t1, lf, 5'h0};
        else if (mode == 2) dout = {8'h0, 1'b0, t1, lf, 1'b0, win, t2, 2'h0};
        else if (mode == 3 && insec) dout = {8'h0, 1'b1, t1, 3'h0, t2, 2'h0};
        else dout = word(addr);
        if (busy) t1 = ~t1;
        if ((mode == 2 || mode == 3) && insec) t2 = ~t2;
    end
endmodule

/* bench/fwsr_ctrl_test.sv */
// self-checking bench for the flash status controller
`include "fwsr_defs.vh"
module fwsr_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, st, q;
    logic        pready, pslverr, dq_oe, cs_n, we_n, oe_n, rst_n, rb_n;
    logic [16:0] fa;
    logic [15:0] dq_out, dq;
    int          errors = 0, checked = 0;

    always #20 pclk = ~pclk;

    fwsr_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_addr(fa), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
        .flash_dq_in(dq), .chip_select_n(cs_n), .write_strobe_n(we_n),
        .output_strobe_n(oe_n), .reset_n(rst_n), .ready_busy_n(rb_n));
    fwsr_flash_model flash (.addr(fa), .dq_host(dq_out), .dq_host_oe(dq_oe), .cs_n(cs_n),
        .we_n(we_n), .oe_n(oe_n), .dq(dq), .ready_busy_n(rb_n));

    task automatic give_verdict;
        if (errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic op(input logic [2:0] c, input logic [16:0] a, input logic [15:0] d);
        apb(1'b1, `FWSR_REG_ADDR, {15'h0, a});
        apb(1'b1, `FWSR_REG_DATA, {16'h0, d});
        apb(1'b1, `FWSR_REG_CMD, {29'h0, c});
        for (int i = 0; i < 3000; i++) begin
            apb(1'b0, `FWSR_REG_STATUS, 32'h0);
            if (q[`FWSR_ST_BUSY] === 1'b0) break;
        end
        st = q;
    endtask
    task automatic rd_arr(input logic [16:0] a, input logic [15:0] e);
        op(`FWSR_OP_READ, a, 16'h0);
        apb(1'b0, `FWSR_REG_RDATA, 32'h0);
        chk(q, {16'h0, e});
    endtask

    initial begin
        logic [16:0] sel_addr [3] = '{17'h00000, 17'h1f002, 17'h01002};
        logic [7:0]  sel_exp [3]  = '{8'h3c, 8'h01, 8'h00};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'({cs_n, we_n, oe_n, dq_oe}), 32'he);
        apb(1'b0, 12'h020, 32'h0);
        chk(q, 32'h0);
        op(`FWSR_OP_PROGRAM, 17'h01234, 16'h0055);
        chk(32'(st[2:0]), 32'h2);
        rd_arr(17'h01234, 16'h0055);
        op(`FWSR_OP_PROGRAM, 17'h1f010, 16'h0000);
        chk(32'(st[2:0]), 32'h2);
        rd_arr(17'h1f010, 16'hffff);
        op(`FWSR_OP_PROGRAM, 17'h02000, 16'h1234);
        op(`FWSR_OP_SECERASE, 17'h01000, 16'h0);
        chk(32'(st[4:0]), 32'h1a);
        rd_arr(17'h01234, 16'hffff);
        rd_arr(17'h02000, 16'h1234);
        // suspend mid-erase, read elsewhere, resume
        op(`FWSR_OP_PROGRAM, 17'h01234, 16'h00aa);
        apb(1'b1, `FWSR_REG_CMD, {29'h0, `FWSR_OP_SECERASE});
        repeat (60) @(posedge pclk);
        op(`FWSR_OP_SUSPEND, 17'h01000, 16'h0);
        chk(32'(st[`FWSR_ST_RDYPIN]), 32'h1);
        rd_arr(17'h02000, 16'h1234);
        op(`FWSR_OP_RESUME, 17'h01000, 16'h0);
        chk(32'(st[2:0]), 32'h2);
        rd_arr(17'h01234, 16'hffff);
        for (int i = 0; i < 3; i++) begin
            op(`FWSR_OP_AUTOSEL, sel_addr[i], 16'h0);
            apb(1'b0, `FWSR_REG_RDATA, 32'h0);
            chk(32'(q[7:0]), 32'(sel_exp[i]));
            op(`FWSR_OP_RESET, 17'h0, 16'h0);
        end
        rd_arr(17'h02000, 16'h1234);
        flash.fail_next = 1'b1;
        op(`FWSR_OP_PROGRAM, 17'h03000, 16'h00aa);
        chk(32'(st[`FWSR_ST_FAIL]), 32'h1);
        flash.fail_next = 1'b0;
        op(`FWSR_OP_RESET, 17'h0, 16'h0);
        rd_arr(17'h03000, 16'hffff);
        op(`FWSR_OP_CHIPERASE, 17'h0, 16'h0);
        chk(32'(st[2:0]), 32'h2);
        rd_arr(17'h02000, 16'hffff);
        give_verdict;
    end

    initial begin
        #2000000;
        errors++;
        give_verdict;
    end
endmodule

bind fwsr_ctrl fwsr_ctrl_sva #(.AW(AW), .DW(DW)) u_sva (.pclk(pclk), .presetn(presetn),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n));
